// File: rtl/spwm_channel_stage.v
// six output pwm channel stage with apb registers, reload and deadtime
// Notes on behaviour
// - independence bit one: pair runs independently
// - independence bit zero: pair is complementary
// - deadtime on each change, three-cycle pin delay
// - center complementary: even up, odd down
// - edge placement xors even and odd pulses
// - top polarity bit makes even outputs low-active
// - bottom polarity for odd outputs, also override
// - independent override drives channel from software bit
// - complementary override: even bit replaces generator
// - odd bit set complements, clear holds inactive
// - override keeps generator; release at cycle start, at once when disabled
// - override works with generator disabled
// - load okay buffers parameters, self clears
// - reload every n opportunities, n one to sixteen
// - half cycle opportunities only when center aligned
// - half-cycle modulus load sets counter modulus minus one
// - flag at every opportunity, irq, cleared writing zero
// - enabling performs immediate reload and sets flag
// - first enable defaults; re-enable reuses last load
// - initial select picks even or odd first cycle
// - disabled: counter cleared, outputs inactive, others live
//
// The register offsets and the APB slave port were decided locally.
`include "spwm_defines.vh"
module spwm_channel_stage (
    input wire mclk,
    input wire arst_n,
    input wire ce,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    output reg [5:0] pwm_out,
    output wire reload_irq
);
    localparam ST_UP = 1'b0;
    localparam ST_DOWN = 1'b1;
    reg en, load_okay, flag, rie, half, prsc_lo, prsc_hi;
    reg [3:0] load_frequency;
    reg [2:0] indep, ipol;
    reg topneg, botneg, edge_al;
    reg [5:0] sw_lvl, sw_en;
    reg [14:0] counter_modulus;
    reg [7:0] deadtime_count;
    reg [5:0] cinv;
    reg [2:0] pec;
    reg [15:0] val_sh [0:5];
    reg [15:0] val_act [0:5];
    reg [14:0] counter_modulus_act;
    reg [1:0] prsc_act;
    reg [14:0] cnt;
    reg dir;
    reg [2:0] pdiv;
    reg [3:0] ldcnt;
    reg en_d, first_cyc;
    reg [5:0] ovr_act;
    reg [5:0] pipe1, pipe2;
    wire acc = psel & penable;
    wire wr = acc & pwrite;
    assign pslverr = 1'b0;
    assign reload_irq = flag & rie;

    function [2:0] val_index;
        input [11:0] a;
        begin
            val_index = a[4:2];
        end
    endfunction
    function is_val;
        input [11:0] a;
        begin
            is_val = (a >= `SPWM_OFF_VAL0) && (a < `SPWM_OFF_VAL0 + 12'h018);
        end
    endfunction

    // shadow duty store, also readable over the bus
    wire [15:0] mem_rdata;
    spwm_value_mem u_mem (
        .mclk(mclk),
        .arst_n(arst_n),
        .ce(ce),
        .we(wr & is_val(paddr)),
        .waddr(val_index(paddr - `SPWM_OFF_VAL0)),
        .wdata(pwdata[15:0]),
        .raddr(val_index(paddr - `SPWM_OFF_VAL0)),
        .rdata(mem_rdata)
    );

    // value reads wait one cycle so the registered memory port can answer
    wire val_rd = acc & ~pwrite & is_val(paddr);
    reg rd_hold;
    assign pready = ~(val_rd & ~rd_hold);
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rd_hold <= 1'b0;
        end else if (ce) begin
            rd_hold <= val_rd & ~rd_hold;
        end
    end

    // prescaled pwm clock tick
    wire [2:0] pdiv_max = (prsc_act == 2'd0) ? 3'd0 : (prsc_act == 2'd1) ? 3'd1 :
                          (prsc_act == 2'd2) ? 3'd3 : 3'd7;
    wire tick = (pdiv == pdiv_max);
    wire cyc_start = en & tick & (edge_al ? (cnt == counter_modulus_act - 15'd1) :
                     (dir == ST_DOWN && cnt <= 15'd1));
    wire half_pt = en & tick & ~edge_al & (dir == ST_UP) & (cnt >= counter_modulus_act - 15'd1);
    wire opp = cyc_start | (half_pt & half & ~edge_al);
    wire do_reload = opp & (ldcnt == load_frequency);
    wire en_rise = en & ~en_d;
    wire load_now = (do_reload | en_rise) & load_okay;
    wire flag_set = opp | en_rise;

    integer k;
    integer ka;
    integer ko;
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            en <= 1'b0;
            load_okay <= 1'b0;
            flag <= 1'b0;
            rie <= 1'b0;
            half <= 1'b0;
            prsc_lo <= 1'b0;
            prsc_hi <= 1'b0;
            load_frequency <= 4'h0;
            indep <= 3'h0;
            ipol <= 3'h0;
            topneg <= 1'b0;
            botneg <= 1'b0;
            edge_al <= 1'b0;
            sw_lvl <= 6'h00;
            sw_en <= 6'h00;
            counter_modulus <= 15'h0000;
            deadtime_count <= 8'h00;
            cinv <= 6'h00;
            pec <= 3'h0;
        end else if (ce) begin
            if (wr && paddr == `SPWM_OFF_CTRL) begin
                en <= pwdata[`SPWM_CTRL_EN];
                if (pwdata[`SPWM_CTRL_LOAD_OKAY]) begin
                    load_okay <= 1'b1;
                end
                rie <= pwdata[`SPWM_CTRL_RIE];
                half <= pwdata[`SPWM_CTRL_HALF];
                prsc_lo <= pwdata[`SPWM_CTRL_PRSC_LO];
                prsc_hi <= pwdata[`SPWM_CTRL_PRSC_HI];
                load_frequency <= pwdata[`SPWM_CTRL_LOAD_FREQUENCY_LSB+3:`SPWM_CTRL_LOAD_FREQUENCY_LSB];
            end
            if (load_now && !(wr && paddr == `SPWM_OFF_CTRL && pwdata[`SPWM_CTRL_LOAD_OKAY])) begin
                load_okay <= 1'b0;
            end
            // set wins over the software clear
            if (flag_set) begin
                flag <= 1'b1;
            end else if (wr && paddr == `SPWM_OFF_CTRL && !pwdata[`SPWM_CTRL_FLAG]) begin
                flag <= 1'b0;
            end
            if (wr && paddr == `SPWM_OFF_CONFIGURE_REG) begin
                indep <= pwdata[`SPWM_CONFIGURE_REG_INDEP_LSB+2:`SPWM_CONFIGURE_REG_INDEP_LSB];
                ipol <= pwdata[`SPWM_CONFIGURE_REG_IPOL_LSB+2:`SPWM_CONFIGURE_REG_IPOL_LSB];
                topneg <= pwdata[`SPWM_CONFIGURE_REG_TOPNEG];
                botneg <= pwdata[`SPWM_CONFIGURE_REG_BOTNEG];
                edge_al <= pwdata[`SPWM_CONFIGURE_REG_EDGE];
            end
            if (wr && paddr == `SPWM_OFF_OUT) begin
                sw_lvl <= pwdata[`SPWM_OUT_LVL_LSB+5:`SPWM_OUT_LVL_LSB];
                sw_en <= pwdata[`SPWM_OUT_EN_LSB+5:`SPWM_OUT_EN_LSB];
            end
            if (wr && paddr == `SPWM_OFF_COUNTER_MODULUS) begin
                counter_modulus <= pwdata[14:0];
            end
            if (wr && paddr == `SPWM_OFF_DEADTIME_COUNT) begin
                deadtime_count <= pwdata[7:0];
            end
            if (wr && paddr == `SPWM_OFF_CINV) begin
                cinv <= pwdata[5:0];
            end
            if (wr && paddr == `SPWM_OFF_PEC) begin
                pec <= pwdata[2:0];
            end
        end
    end

    // shadow copy kept beside the memory so all six load in one cycle
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            for (k = 0; k < 6; k = k + 1) begin
                val_sh[k] <= 16'h0000;
                val_act[k] <= 16'h0000;
            end
            counter_modulus_act <= 15'h0000;
            prsc_act <= 2'd0;
        end else if (ce) begin
            for (k = 0; k < 6; k = k + 1) begin
                if (wr && is_val(paddr) && val_index(paddr - `SPWM_OFF_VAL0) == k[2:0]) begin
                    val_sh[k] <= pwdata[15:0];
                end
                if (load_now) begin
                    val_act[k] <= val_sh[k];
                end
            end
            if (load_now) begin
                counter_modulus_act <= counter_modulus;
                prsc_act <= {prsc_hi, prsc_lo};
            end
        end
    end

    // counter, direction, reload divider
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 15'h0000;
            dir <= ST_UP;
            pdiv <= 3'd0;
            ldcnt <= 4'h0;
            en_d <= 1'b0;
            first_cyc <= 1'b0;
        end else if (ce) begin
            en_d <= en;
            if (!en) begin
                cnt <= 15'h0000;
                dir <= ST_UP;
                pdiv <= 3'd0;
                ldcnt <= 4'h0;
                first_cyc <= 1'b0;
            end else begin
                if (en_rise) begin
                    first_cyc <= 1'b1;
                end else if (cyc_start) begin
                    first_cyc <= 1'b0;
                end
                if (opp) begin
                    ldcnt <= (ldcnt == load_frequency) ? 4'h0 : ldcnt + 4'h1;
                end
                pdiv <= tick ? 3'd0 : pdiv + 3'd1;
                if (half_pt && load_now && !edge_al) begin
                    cnt <= counter_modulus - 15'd1;
                    dir <= ST_DOWN;
                end else if (tick) begin
                    case (dir)
                        ST_UP: begin
                            if (cnt >= counter_modulus_act - 15'd1) begin
                                cnt <= edge_al ? 15'h0000 : counter_modulus_act;
                                dir <= edge_al ? ST_UP : ST_DOWN;
                            end else begin
                                cnt <= cnt + 15'd1;
                            end
                        end
                        ST_DOWN: begin
                            if (cnt <= 15'd1) begin
                                cnt <= 15'h0000;
                                dir <= ST_UP;
                            end else begin
                                cnt <= cnt - 15'd1;
                            end
                        end
                        default: begin
                            dir <= ST_UP;
                        end
                    endcase
                end
            end
        end
    end

    // compare outputs per channel; negative values read as zero
    wire [5:0] cmp;
    wire [5:0] pair_src;
    wire [5:0] top_act, bot_act;
    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1) begin : g_cmp
            wire [15:0] v = val_act[g][15] ? 16'h0000 : val_act[g];
            assign cmp[g] = en & (({1'b0, cnt} < v) ^ cinv[g]);
        end
        for (g = 0; g < 3; g = g + 1) begin : g_pair
            wire sel_odd = first_cyc ? ipol[g] : (dir == ST_DOWN);
            wire gen_src = (edge_al && pec[g]) ? (cmp[2*g] ^ cmp[2*g+1]) :
                           (edge_al ? (first_cyc && ipol[g] ? cmp[2*g+1] : cmp[2*g]) :
                           (sel_odd ? cmp[2*g+1] : cmp[2*g]));
            wire src = ovr_act[2*g] ? sw_lvl[2*g] : gen_src;
            spwm_deadtime u_dt (
                .mclk(mclk),
                .arst_n(arst_n),
                .ce(ce),
                .tick(tick | ~en),
                .src(src),
                .dead(deadtime_count),
                .top_act(top_act[2*g]),
                .bot_act(bot_act[2*g])
            );
            assign top_act[2*g+1] = 1'b0;
            assign bot_act[2*g+1] = 1'b0;
            // odd software bit only gates the bottom output
            assign pair_src[2*g] = top_act[2*g];
            assign pair_src[2*g+1] = bot_act[2*g] &
                (~ovr_act[2*g+1] | sw_lvl[2*g+1]);
        end
    endgenerate

    // override release waits for next cycle start, or is immediate while disabled
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ovr_act <= 6'h00;
        end else if (ce) begin
            for (ko = 0; ko < 6; ko = ko + 1) begin
                if (sw_en[ko]) begin
                    ovr_act[ko] <= 1'b1;
                end else if (cyc_start || !en) begin
                    ovr_act[ko] <= 1'b0;
                end
            end
        end
    end

    // activity per channel, then polarity and three-cycle pipe
    reg [5:0] act;
    always @* begin
        for (ka = 0; ka < 6; ka = ka + 1) begin
            if (indep[ka/2]) begin
                act[ka] = ovr_act[ka] ? sw_lvl[ka] : cmp[ka];
            end else begin
                // deadtime idles with bottom on, so a disabled pair is gated off
                act[ka] = pair_src[ka] & (en | ovr_act[2*(ka/2)]);
            end
        end
    end
    wire [5:0] pol = {botneg, topneg, botneg, topneg, botneg, topneg};
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pipe1 <= 6'h00;
            pipe2 <= 6'h00;
            pwm_out <= 6'h00;
        end else if (ce) begin
            pipe1 <= act;
            pipe2 <= pipe1;
            pwm_out <= pipe2 ^ pol;
        end
    end

    // read mux, registered on the setup phase; values one cycle later
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            prdata <= 32'h00000000;
        end else if (ce && val_rd && !rd_hold) begin
            prdata <= {16'h0000, mem_rdata};
        end else if (ce && psel && !penable) begin
            case (paddr)
                `SPWM_OFF_CTRL: prdata <= {20'h00000, load_frequency, 1'b0, prsc_hi, prsc_lo, half,
                                          rie, flag, load_okay, en};
                `SPWM_OFF_CONFIGURE_REG: prdata <= {23'h000000, edge_al, botneg, topneg, ipol, indep};
                `SPWM_OFF_OUT: prdata <= {18'h00000, sw_en, 2'b00, sw_lvl};
                `SPWM_OFF_COUNTER_MODULUS: prdata <= {17'h00000, counter_modulus};
                `SPWM_OFF_DEADTIME_COUNT: prdata <= {24'h000000, deadtime_count};
                `SPWM_OFF_CINV: prdata <= {26'h0000000, cinv};
                `SPWM_OFF_PEC: prdata <= {29'h00000000, pec};
                `SPWM_OFF_CNT: prdata <= {17'h00000, cnt};
                default: prdata <= 32'h00000000;
            endcase
        end
    end
endmodule

// File: include/spwm_defines.vh
// register offsets, fields and timing constants of the pwm channel stage
`ifndef SPWM_DEFINES_VH
`define SPWM_DEFINES_VH
`define SPWM_OFF_CTRL 12'h000
`define SPWM_OFF_CONFIGURE_REG 12'h004
`define SPWM_OFF_OUT 12'h008
`define SPWM_OFF_COUNTER_MODULUS 12'h00c
`define SPWM_OFF_DEADTIME_COUNT 12'h010
`define SPWM_OFF_CINV 12'h014
`define SPWM_OFF_PEC 12'h018
`define SPWM_OFF_CNT 12'h01c
`define SPWM_OFF_VAL0 12'h020
`define SPWM_CTRL_EN 0
`define SPWM_CTRL_LOAD_OKAY 1
`define SPWM_CTRL_FLAG 2
`define SPWM_CTRL_RIE 3
`define SPWM_CTRL_HALF 4
`define SPWM_CTRL_PRSC_LO 5
`define SPWM_CTRL_PRSC_HI 6
`define SPWM_CTRL_LOAD_FREQUENCY_LSB 8
`define SPWM_CONFIGURE_REG_INDEP_LSB 0
`define SPWM_CONFIGURE_REG_IPOL_LSB 3
`define SPWM_CONFIGURE_REG_TOPNEG 6
`define SPWM_CONFIGURE_REG_BOTNEG 7
`define SPWM_CONFIGURE_REG_EDGE 8
`define SPWM_OUT_LVL_LSB 0
`define SPWM_OUT_EN_LSB 8
`define SPWM_PIPE_DELAY 2
`define SPWM_CNT_W 15
`endif

// File: rtl/spwm_value_mem.v
// six-word duty value store with registered read port
module spwm_value_mem (
    input wire mclk,
    input wire arst_n,
    input wire ce,
    input wire we,
    input wire [2:0] waddr,
    input wire [15:0] wdata,
    input wire [2:0] raddr,
    output reg [15:0] rdata
);
    reg [15:0] mem [0:5];
    integer i;
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            for (i = 0; i < 6; i = i + 1) begin
                mem[i] <= 16'h0000;
            end
            rdata <= 16'h0000;
        end else if (ce) begin
            if (we && waddr < 3'd6) begin
                mem[waddr] <= wdata;
            end
            rdata <= (raddr < 3'd6) ? mem[raddr] : 16'h0000;
        end
    end
endmodule

// File: rtl/spwm_deadtime.v
// deadtime insertion for one complementary pair
module spwm_deadtime (
    input wire mclk,
    input wire arst_n,
    input wire ce,
    input wire tick,
    input wire src,
    input wire [7:0] dead,
    output reg top_act,
    output reg bot_act
);
    reg last;
    reg [7:0] cnt;
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            last <= 1'b0;
            cnt <= 8'h00;
            top_act <= 1'b0;
            bot_act <= 1'b0;
        end else if (ce) begin
            if (src != last) begin
                last <= src;
                cnt <= dead;
                top_act <= 1'b0;
                bot_act <= 1'b0;
            end else if (cnt != 8'h00) begin
                if (tick) begin
                    cnt <= cnt - 8'h01;
                end
            end else begin
                top_act <= last;
                bot_act <= ~last;
            end
        end
    end
endmodule

// File: bench/spwm_stage_checker.sv
// pin, flag and override checks on the pwm channel stage ports
`include "spwm_defines.vh"
module spwm_stage_checker (
    input wire mclk,
    input wire arst_n,
    input wire ce,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [5:0] pwm_out,
    input wire reload_irq
);
    logic en_q, tn, bn, wr, wc;
    logic [2:0] ind;
    logic [13:0] ov;
    logic [7:0] dt, qt;
    logic [5:0] act, im;
    assign wr = psel & penable & pwrite & ce;
    assign wc = wr && (paddr == `SPWM_OFF_CTRL);
    assign act = pwm_out ^ {3{bn, tn}};
    assign im = {ind[2], ind[2], ind[1], ind[1], ind[0], ind[0]};
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            en_q <= 1'b0;
            {bn, tn, ind} <= 5'h0;
            ov <= 14'h0;
            dt <= 8'h0;
        end else if (wr) begin
            if (paddr == `SPWM_OFF_CTRL) en_q <= pwdata[0];
            if (paddr == `SPWM_OFF_CONFIGURE_REG) {bn, tn, ind} <= {pwdata[7:6], pwdata[2:0]};
            if (paddr == `SPWM_OFF_OUT) ov <= pwdata[13:0];
            if (paddr == `SPWM_OFF_DEADTIME_COUNT) dt <= pwdata[7:0];
        end
    end
    // quiet time since the last control write, so pipeline latency has settled
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) qt <= 8'h0;
        else if (wr && paddr <= `SPWM_OFF_DEADTIME_COUNT) qt <= 8'h0;
        else if (qt != 8'hff) qt <= qt + 8'h1;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    irq_on_enable_a: assert property (wc && pwdata[0] && pwdata[3] && !en_q
        |-> ##[1:3] reload_irq)
        else $error("no reload request after enable");
    irq_masked_a: assert property (wc && !pwdata[3] |=> !reload_irq)
        else $error("reload request while masked");
    pair_overlap_a: assert property (qt > 8'd4
        |-> (act[4:0] & act[5:1] & ~im[4:0] & 5'h15) == 5'h0)
        else $error("both outputs of a pair active");
    idle_inactive_a: assert property (qt > 8'd4 && !en_q && ov[13:8] == 6'h0
        |-> act == 6'h0)
        else $error("output active while disabled");
    indep_override_a: assert property (qt > 8'd4
        |-> ((act ^ ov[5:0]) & ov[13:8] & im) == 6'h0)
        else $error("independent override level wrong");
    odd_held_a: assert property (qt > 8'd4 && !ind[0] && ov[9] && !ov[1] |-> !act[1])
        else $error("odd output not held inactive");
    comp_follow_a: assert property (!en_q && !ind[0] && ov[9:8] == 2'b11 && ov[1] && qt > dt + 8'd4
        |-> act[1:0] == {!ov[0], ov[0]})
        else $error("complementary override pair wrong");
    deadtime_gap_a: assert property (wr && paddr == `SPWM_OFF_OUT && !ind[0]
        && ov[9:8] == 2'b11 && pwdata[9:8] == 2'b11 && pwdata[0] != ov[0]
        && dt >= 8'd8 && qt > 8'd20 |-> ##5 !act[0] && !act[1])
        else $error("no deadtime after even toggle");
    cover property (wc && pwdata[0]);
    cover property (reload_irq);
    cover property (qt > 8'd20 && ov[8] && !ind[0]);
endmodule

// File: bench/spwm_gate_drv.sv
// gate driver model: counts cycles in which any leg marked in comp_pair has both transistors switched on
module spwm_gate_drv (
    input wire mclk,
    input wire [5:0] pwm_out,
    input wire top_low,
    input wire bot_low,
    input wire [2:0] comp_pair,
    output int shoot_count
);
    logic [5:0] on;
    assign on = pwm_out ^ {3{bot_low, top_low}};
    initial shoot_count = 0;
    // only complementary legs share a bus rail; independent pins may overlap
    always @(posedge mclk) begin
        if (|(on[4:0] & on[5:1] & {comp_pair[2], 1'b0, comp_pair[1], 1'b0, comp_pair[0]}))
            shoot_count <= shoot_count + 1;
    end
endmodule

// File: bench/testbench.sv
// self-checking bench of the pwm channel stage
`include "spwm_defines.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, arst_n = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, rd;
    wire [31:0] prdata;
    wire pready, pslverr, reload_irq;
    wire [5:0] pwm_out;
    logic [2:0] gd_comp = 3'h0;
    logic [5:0] lvl;
    logic [1:0] pol;
    int shoot_count, err_total = 0, num_checks = 0, cycles = 0, n, i, m;
    integer seed = 81741;
    logic [11:0] ra[7] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h01c, 12'h100};
    logic [31:0] cf[4] = '{32'h107, 32'h107, 32'h007, 32'h007};
    logic [31:0] ct[4] = '{32'h009, 32'h209, 32'h009, 32'h019};
    int pe[4] = '{40, 40, 80, 40};
    always #2 mclk = ~mclk;
    spwm_channel_stage DUT (.mclk(mclk), .arst_n(arst_n), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pwm_out(pwm_out), .reload_irq(reload_irq));
    spwm_gate_drv gd (.mclk(mclk), .pwm_out(pwm_out), .top_low(1'b0), .bot_low(1'b0),
        .comp_pair(gd_comp), .shoot_count(shoot_count));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task settle(input int k);
        repeat (k) @(posedge mclk);
        @(negedge mclk);
    endtask
    // clear the flag, then count cycles to the next reload opportunity
    task gap(input logic [31:0] c, output int k);
        apb(1'b1, `SPWM_OFF_CTRL, c);
        k = 0;
        // the old flag still shows in the time step of the clearing edge
        do begin
            @(negedge mclk);
            k++;
        end while (reload_irq !== 1'b1 && k < 2000);
    endtask
    function logic [5:0] comp_pins(input logic [5:0] l);
        return {l[5] & ~l[4], l[4], l[3] & ~l[2], l[2], l[1] & ~l[0], l[0]};
    endfunction
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            test_done;
        end
    end
    initial begin
        repeat (12) @(posedge mclk);
        arst_n <= 1'b1;
        foreach (ra[j]) begin
            apb(1'b0, ra[j], 32'h0);
            check(rd, 32'h0);
        end
        check(pwm_out, 6'h0);
        $display("reset values done");
        for (i = 0; i < 6; i++) begin
            lvl = 6'($random(seed));
            pol = 2'($random(seed));
            apb(1'b1, `SPWM_OFF_CONFIGURE_REG, {24'h0, pol, 6'h07});
            apb(1'b1, `SPWM_OFF_OUT, {18'h0, 6'h3f, 2'b00, lvl});
            settle(6);
            check(pwm_out, lvl ^ {3{pol}});
        end
        $display("independent override done");
        apb(1'b1, `SPWM_OFF_DEADTIME_COUNT, 32'h8);
        apb(1'b1, `SPWM_OFF_OUT, 32'h3f00);
        apb(1'b1, `SPWM_OFF_CONFIGURE_REG, 32'h0);
        settle(24);
        gd_comp = 3'h7;
        for (i = 0; i < 8; i++) begin
            lvl = 6'($random(seed));
            apb(1'b1, `SPWM_OFF_OUT, {18'h0, 6'h3f, 2'b00, lvl});
            settle(24);
            check(pwm_out, comp_pins(lvl));
        end
        apb(1'b1, `SPWM_OFF_OUT, 32'h0);
        settle(24);
        gd_comp = 3'h0;
        check(pwm_out, 6'h0);
        $display("complementary override done");
        apb(1'b1, `SPWM_OFF_COUNTER_MODULUS, 32'd40);
        for (i = 0; i < 6; i++) begin
            m = $random(seed) & 31;
            apb(1'b1, `SPWM_OFF_VAL0 + 12'(4 * i), 32'(m));
        end
        apb(1'b0, `SPWM_OFF_VAL0 + 12'h014, 32'h0);
        check(rd, 32'(m));
        apb(1'b1, `SPWM_OFF_CONFIGURE_REG, 32'h107);
        apb(1'b0, `SPWM_OFF_CTRL, 32'h0); // read before setting load okay
        apb(1'b1, `SPWM_OFF_CTRL, 32'h2);
        apb(1'b0, `SPWM_OFF_CTRL, 32'h0);
        check(rd[1], 1'b1);
        apb(1'b1, `SPWM_OFF_CTRL, 32'h9);
        settle(4);
        check(reload_irq, 1'b1);
        apb(1'b0, `SPWM_OFF_CTRL, 32'h0);
        check(rd[2:1], 2'b10);
        apb(1'b1, `SPWM_OFF_CTRL, 32'h5);
        settle(1);
        check(reload_irq, 1'b0);
        $display("load and enable done");
        for (i = 0; i < 4; i++) begin
            apb(1'b1, `SPWM_OFF_CONFIGURE_REG, cf[i]);
            repeat (2) gap(ct[i], n);
            gap(ct[i], n);
            check(32'(n > pe[i] - 10 && n <= pe[i]), 32'h1);
        end
        $display("reload rate done");
        for (i = 0; i < 2; i++) begin
            apb(1'b0, `SPWM_OFF_CTRL, 32'h0);
            apb(1'b1, `SPWM_OFF_CTRL, 32'h20b);
            n = 0;
            do begin
                gap(32'h209, m);
                apb(1'b0, `SPWM_OFF_CTRL, 32'h0);
                n++;
            end while (rd[1] === 1'b1 && n < 8);
        end
        check(n, 3);
        $display("load rate done");
        apb(1'b1, `SPWM_OFF_CTRL, 32'h4);
        apb(1'b0, `SPWM_OFF_CNT, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, `SPWM_OFF_CTRL, 32'h0);
        check(rd[2], 1'b1);
        settle(6);
        check(pwm_out, 6'h0);
        @(posedge mclk);
        ce <= 1'b0;
        apb(1'b1, `SPWM_OFF_DEADTIME_COUNT, 32'h5);
        @(posedge mclk);
        ce <= 1'b1;
        apb(1'b0, `SPWM_OFF_DEADTIME_COUNT, 32'h0);
        check(rd, 32'h8);
        check(shoot_count, 0);
        $display("disable done");
        test_done;
    end
endmodule
bind spwm_channel_stage spwm_stage_checker chk (.mclk(mclk), .arst_n(arst_n), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwm_out(pwm_out),
    .reload_irq(reload_irq));
